//--- hfpb_fan_alarm.sv
// Purpose: indexed host register window, two fan drives and the alarm tone pin
// Assumes: host strobes are one-cycle pulses on core_clk; event inputs on core_clk
// Notes: source clock pins are sampled, so the fast source must stay below half core_clk
`timescale 1ns/1ps
`default_nettype none
module hfpb_fan_alarm #(
    parameter int PHASE_CYCLES = hfpb_pkg::PHASE_CYCLES,
    parameter int LOW_HALF_CYCLES = hfpb_pkg::LOW_HALF_CYCLES,
    parameter int HIGH_HALF_CYCLES = hfpb_pkg::HIGH_HALF_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // host io cycle
    input wire hfpb_pkg::hfpb_io_req_t ioReq,
    output logic [7:0] ioRdData,
    output logic ioRdValid,
    // base address bytes
    input wire logic [7:0] monitorBaseHigh,
    input wire logic [7:0] monitorBaseLow,
    // pins from outside
    input wire logic srcFastClkPin,
    input wire logic srcSlowClkPin,
    input wire logic fanSetStrap,
    // monitored events
    input wire logic [hfpb_pkg::ALARM_EVENTS-1:0] alarmEvents,
    // fan drives
    output logic systemFanPwm,
    output logic [5:0] systemFanDcLevel,
    output logic systemFanTypeSelect,
    output logic processorFanPwm,
    output logic [5:0] processorFanDcLevel,
    output logic processorFanTypeSelect,
    // alarm pin, open drain
    input wire logic alarmTonePinIn,
    output logic alarmTonePinOut,
    output logic alarmTonePinOe
);
    import hfpb_pkg::*;

    localparam int PHASE_W = $clog2(PHASE_CYCLES + 1);
    localparam int HALF_W = $clog2(LOW_HALF_CYCLES + HIGH_HALF_CYCLES + 1);

    // ========================================
    // pin synchronisers
    logic [1:0] fastSync_q, slowSync_q, strapSync_q;
    logic fastPrev_q, slowPrev_q;
    logic fastTick, slowTick;

    // the second stage alone feeds the edge detectors
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            fastSync_q <= 2'b00;
            slowSync_q <= 2'b00;
            strapSync_q <= 2'b00;
            fastPrev_q <= 1'b0;
            slowPrev_q <= 1'b0;
        end else begin
            fastSync_q <= {fastSync_q[0], srcFastClkPin};
            slowSync_q <= {slowSync_q[0], srcSlowClkPin};
            strapSync_q <= {strapSync_q[0], fanSetStrap};
            fastPrev_q <= fastSync_q[1];
            slowPrev_q <= slowSync_q[1];
        end
    end

    assign fastTick = fastSync_q[1] && !fastPrev_q;
    assign slowTick = slowSync_q[1] && !slowPrev_q;

    // ========================================
    // host register window
    logic [6:0] indexPtr_q, indexPtr_d;
    logic [7:0] bankSel_q, bankSel_d;
    logic [7:0] sysFreq_q, sysFreq_d, cpuFreq_q, cpuFreq_d;
    logic [7:0] sysValue_q, sysValue_d, cpuValue_q, cpuValue_d;
    logic [7:0] fanCfg_q, fanCfg_d;
    logic [7:0] alarmEnA_q, alarmEnA_d, alarmEnB_q, alarmEnB_d;
    logic [1:0] alarmEnC_q, alarmEnC_d;
    logic [7:0] ioRdData_q, ioRdData_d;
    logic ioRdValid_q, ioRdValid_d;
    logic [1:0] strapWait_q, strapWait_d;
    logic strapDone_q, strapDone_d;
    logic [15:0] baseAddr, indexPort, dataPort;
    logic hitIndex, hitData, banked, inAlarmBank, inBankC;
    logic [7:0] selRead;

    always_comb begin
        baseAddr = {monitorBaseHigh, monitorBaseLow};
        indexPort = baseAddr + PORT_INDEX_OFS;
        dataPort = baseAddr + PORT_DATA_OFS;
        hitIndex = ioReq.addr == indexPort;
        hitData = ioReq.addr == dataPort;
        banked = indexPtr_q >= IDX_BANKED_FIRST;
        inAlarmBank = banked && bankSel_q == BANK_ALARM_AB;
        inBankC = banked && bankSel_q == BANK_ALARM_C;
        // selected register read, unimplemented slots read zero
        selRead = 8'h00;
        case (indexPtr_q)
            IDX_SYS_FREQ: selRead = sysFreq_q;
            IDX_SYS_VALUE: selRead = sysValue_q;
            IDX_CPU_FREQ: selRead = cpuFreq_q;
            IDX_CPU_VALUE: selRead = cpuValue_q;
            IDX_FAN_CFG: selRead = fanCfg_q;
            IDX_BANK_SEL: selRead = bankSel_q;
            IDX_ALARM_EN_A: selRead = inAlarmBank ? alarmEnA_q : 8'h00;
            IDX_ALARM_EN_B: selRead = inAlarmBank ? alarmEnB_q : 8'h00;
            IDX_ALARM_EN_C: selRead = inBankC ? {6'h00, alarmEnC_q} : 8'h00;
            default: selRead = 8'h00;
        endcase
        indexPtr_d = indexPtr_q;
        bankSel_d = bankSel_q;
        sysFreq_d = sysFreq_q;
        cpuFreq_d = cpuFreq_q;
        sysValue_d = sysValue_q;
        cpuValue_d = cpuValue_q;
        fanCfg_d = fanCfg_q;
        alarmEnA_d = alarmEnA_q;
        alarmEnB_d = alarmEnB_q;
        alarmEnC_d = alarmEnC_q;
        ioRdData_d = ioRdData_q;
        ioRdValid_d = 1'b0;
        strapWait_d = strapWait_q;
        strapDone_d = strapDone_q;
        if (ioReq.wr && hitIndex) begin
            indexPtr_d = ioReq.wdata[6:0];
        end
        if (ioReq.wr && hitData) begin
            case (indexPtr_q)
                IDX_SYS_FREQ: sysFreq_d = ioReq.wdata;
                IDX_SYS_VALUE: sysValue_d = ioReq.wdata;
                IDX_CPU_FREQ: cpuFreq_d = ioReq.wdata;
                IDX_CPU_VALUE: cpuValue_d = ioReq.wdata;
                IDX_FAN_CFG: fanCfg_d = ioReq.wdata;
                IDX_BANK_SEL: bankSel_d = ioReq.wdata;
                IDX_ALARM_EN_A: if (inAlarmBank) alarmEnA_d = ioReq.wdata;
                IDX_ALARM_EN_B: if (inAlarmBank) alarmEnB_d = ioReq.wdata;
                IDX_ALARM_EN_C: if (inBankC) alarmEnC_d = ioReq.wdata[1:0];
                default: ;
            endcase
        end
        if (ioReq.rd && (hitIndex || hitData)) begin
            ioRdData_d = hitIndex ? {1'b0, indexPtr_q} : selRead;
            ioRdValid_d = 1'b1;
        end
        // strap is caught once the synchroniser has filled after release
        if (!strapDone_q) begin
            if (strapWait_q == 2'(STRAP_SETTLE)) begin
                strapDone_d = 1'b1;
                sysValue_d = strapSync_q[1] ? STRAP_HIGH_VALUE : STRAP_LOW_VALUE;
                cpuValue_d = strapSync_q[1] ? STRAP_HIGH_VALUE : STRAP_LOW_VALUE;
            end else begin
                strapWait_d = strapWait_q + 2'b01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            indexPtr_q <= INDEX_RST;
            bankSel_q <= BANK_RST;
            sysFreq_q <= FREQ_RST;
            cpuFreq_q <= FREQ_RST;
            sysValue_q <= 8'h00;
            cpuValue_q <= 8'h00;
            fanCfg_q <= FAN_CFG_RST;
            alarmEnA_q <= 8'h00;
            alarmEnB_q <= 8'h00;
            alarmEnC_q <= 2'b00;
            ioRdData_q <= 8'h00;
            ioRdValid_q <= 1'b0;
            strapWait_q <= 2'b00;
            strapDone_q <= 1'b0;
        end else begin
            indexPtr_q <= indexPtr_d;
            bankSel_q <= bankSel_d;
            sysFreq_q <= sysFreq_d;
            cpuFreq_q <= cpuFreq_d;
            sysValue_q <= sysValue_d;
            cpuValue_q <= cpuValue_d;
            fanCfg_q <= fanCfg_d;
            alarmEnA_q <= alarmEnA_d;
            alarmEnB_q <= alarmEnB_d;
            alarmEnC_q <= alarmEnC_d;
            ioRdData_q <= ioRdData_d;
            ioRdValid_q <= ioRdValid_d;
            strapWait_q <= strapWait_d;
            strapDone_q <= strapDone_d;
        end
    end

    assign ioRdData = ioRdData_q;
    assign ioRdValid = ioRdValid_q;
    assign systemFanTypeSelect = fanCfg_q[CFG_SYS_SEL_BIT];
    assign processorFanTypeSelect = fanCfg_q[CFG_CPU_SEL_BIT];

    // ========================================
    // fan channels; dc mode blanks the pwm path so the frequency has no effect
    hfpb_pwm_channel u_sys_fan (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .srcFastTick(fastTick),
        .srcSlowTick(slowTick),
        .freq(hfpb_freq_t'(sysFreq_q)),
        .duty(sysValue_q),
        .dcMode(systemFanTypeSelect),
        .pwmOut(systemFanPwm),
        .dcLevel(systemFanDcLevel)
    );

    hfpb_pwm_channel u_cpu_fan (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .srcFastTick(fastTick),
        .srcSlowTick(slowTick),
        .freq(hfpb_freq_t'(cpuFreq_q)),
        .duty(cpuValue_q),
        .dcMode(processorFanTypeSelect),
        .pwmOut(processorFanPwm),
        .dcLevel(processorFanDcLevel)
    );

    // ========================================
    // alarm tone sequencer
    hfpb_tone_t tone_q, tone_d;
    logic [PHASE_W-1:0] phaseCnt_q, phaseCnt_d;
    logic [HALF_W-1:0] halfCnt_q, halfCnt_d;
    logic wave_q, wave_d;
    logic alarmActive;
    logic [HALF_W-1:0] halfLimit;

    always_comb begin
        alarmActive = alarmEnB_q[ALARM_GLOBAL_BIT] &&
            |(alarmEvents & {alarmEnC_q, alarmEnB_q[6:0], alarmEnA_q});
        halfLimit = (tone_q == TONE_HIGH) ? HALF_W'(HIGH_HALF_CYCLES - 1) : HALF_W'(LOW_HALF_CYCLES - 1);
        tone_d = tone_q;
        phaseCnt_d = phaseCnt_q;
        halfCnt_d = halfCnt_q;
        wave_d = wave_q;
        case (tone_q)
            TONE_IDLE: begin
                phaseCnt_d = '0;
                halfCnt_d = '0;
                wave_d = 1'b0;
                if (alarmActive) begin
                    tone_d = TONE_LOW;
                end
            end
            TONE_LOW, TONE_HIGH: begin
                if (halfCnt_q >= halfLimit) begin
                    halfCnt_d = '0;
                    wave_d = !wave_q;
                end else begin
                    halfCnt_d = halfCnt_q + 1'b1;
                end
                if (phaseCnt_q >= PHASE_W'(PHASE_CYCLES - 1)) begin
                    phaseCnt_d = '0;
                    halfCnt_d = '0;
                    tone_d = (tone_q == TONE_LOW) ? TONE_HIGH : TONE_LOW;
                end else begin
                    phaseCnt_d = phaseCnt_q + 1'b1;
                end
                // clearing the enable or the event stops the tone at once
                if (!alarmActive) begin
                    tone_d = TONE_IDLE;
                    wave_d = 1'b0;
                end
            end
            default: begin
                tone_d = TONE_IDLE;
                wave_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            tone_q <= TONE_IDLE;
            phaseCnt_q <= '0;
            halfCnt_q <= '0;
            wave_q <= 1'b0;
        end else begin
            tone_q <= tone_d;
            phaseCnt_q <= phaseCnt_d;
            halfCnt_q <= halfCnt_d;
            wave_q <= wave_d;
        end
    end

    // low half of the wave pulls the pin down, high half lets it float up
    assign alarmTonePinOut = 1'b0;
    assign alarmTonePinOe = !wave_q;

    // ========================================
    // checks
    a_index_readback: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ioReq.rd && hitIndex) |=> ioRdValid && !ioRdData[7] && ioRdData[6:0] == $past(indexPtr_q))
        else $error("index port readback wrong");
    a_index_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ioReq.wr && hitIndex) |=> indexPtr_q == $past(ioReq.wdata[6:0]))
        else $error("index pointer not loaded");
    a_data_read: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ioReq.rd && hitData && !hitIndex && indexPtr_q == IDX_SYS_FREQ) |=> ioRdData == $past(sysFreq_q))
        else $error("data port read wrong register");
    a_bank_steer: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ioReq.wr && hitData && indexPtr_q == IDX_ALARM_EN_A && bankSel_q != BANK_ALARM_AB)
        |=> $stable(alarmEnA_q)) else $error("banked write leaked to wrong bank");
    a_global_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        !alarmEnB_q[ALARM_GLOBAL_BIT] |=> ##1 alarmTonePinOe) else $error("tone without global enable");
    a_event_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        !alarmActive |=> tone_q == TONE_IDLE) else $error("tone without enabled event");
    a_idle_low: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tone_q == TONE_IDLE) |-> (alarmTonePinOe && !alarmTonePinOut)) else $error("idle pin not low");
    a_half_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tone_q == TONE_LOW) |-> halfCnt_q < HALF_W'(LOW_HALF_CYCLES)) else $error("low tone half too long");
    a_phase_swap: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tone_q == TONE_LOW && alarmActive && phaseCnt_q == PHASE_W'(PHASE_CYCLES - 1)) |=> tone_q == TONE_HIGH)
        else $error("tone phase did not swap");
    a_dc_blank: assert property (@(posedge core_clk) disable iff (!rst_b)
        systemFanTypeSelect [*2] |-> !systemFanPwm) else $error("system fan pwm in dc mode");
    a_strap_load: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!strapDone_q && strapWait_q == 2'(STRAP_SETTLE)) |=>
        sysValue_q == ($past(strapSync_q[1]) ? STRAP_HIGH_VALUE : STRAP_LOW_VALUE))
        else $error("strap value not loaded");
    c_alarm_on: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(alarmActive));
    c_tone_high: cover property (@(posedge core_clk) disable iff (!rst_b) tone_q == TONE_HIGH);
    c_data_read: cover property (@(posedge core_clk) disable iff (!rst_b) ioReq.rd && hitData);
    c_pin_float: cover property (@(posedge core_clk) disable iff (!rst_b) !alarmTonePinOe && alarmTonePinIn);
endmodule
`default_nettype wire

//--- hfpb_pkg.sv
// Purpose: shared constants and types for the fan drive and alarm tone block
// Assumes: 50 MHz core clock, host port strobes already on that clock
// Notes: derived cycle counts are defaults; the top module re-exposes them as parameters
package hfpb_pkg;
    // ========================================
    // timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TONE_LOW_HZ = 600;
    localparam int TONE_HIGH_HZ = 1200;
    localparam int TONE_PHASE_MS = 500;
    localparam int PHASE_CYCLES = CLK_HZ / 1000 * TONE_PHASE_MS;
    localparam int LOW_HALF_CYCLES = CLK_HZ / (2 * TONE_LOW_HZ);
    localparam int HIGH_HALF_CYCLES = CLK_HZ / (2 * TONE_HIGH_HZ);
    localparam int STRAP_SETTLE = 3;

    // ========================================
    // host ports, offsets from the monitor base address
    localparam logic [15:0] PORT_INDEX_OFS = 16'h0005;
    localparam logic [15:0] PORT_DATA_OFS = 16'h0006;

    // ========================================
    // register indexes
    localparam logic [6:0] IDX_SYS_FREQ = 7'h00;
    localparam logic [6:0] IDX_SYS_VALUE = 7'h01;
    localparam logic [6:0] IDX_CPU_FREQ = 7'h02;
    localparam logic [6:0] IDX_CPU_VALUE = 7'h03;
    localparam logic [6:0] IDX_FAN_CFG = 7'h04;
    localparam logic [6:0] IDX_BANK_SEL = 7'h4e;
    localparam logic [6:0] IDX_BANKED_FIRST = 7'h50;
    localparam logic [6:0] IDX_ALARM_EN_C = 7'h53;
    localparam logic [6:0] IDX_ALARM_EN_A = 7'h56;
    localparam logic [6:0] IDX_ALARM_EN_B = 7'h57;
    localparam logic [7:0] BANK_ALARM_AB = 8'h00;
    localparam logic [7:0] BANK_ALARM_C = 8'h04;

    // ========================================
    // reset values and fields
    localparam logic [6:0] INDEX_RST = 7'h00;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [7:0] FREQ_RST = 8'h04;
    localparam logic [7:0] FAN_CFG_RST = 8'h01;
    localparam logic [7:0] STRAP_HIGH_VALUE = 8'hff;
    localparam logic [7:0] STRAP_LOW_VALUE = 8'h80;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam int CFG_SYS_SEL_BIT = 0;
    localparam int CFG_CPU_SEL_BIT = 1;
    localparam int ALARM_GLOBAL_BIT = 7;
    localparam int ALARM_EVENTS = 17;

    // ========================================
    // types
    typedef struct packed {
        logic [15:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } hfpb_io_req_t;

    typedef struct packed {
        logic clkSel;
        logic [6:0] scale;
    } hfpb_freq_t;

    typedef enum logic [1:0] {TONE_IDLE, TONE_LOW, TONE_HIGH} hfpb_tone_t;
endpackage

//--- hfpb_pwm_channel.sv
// Purpose: one fan drive channel, prescaled pwm or dc level
// Assumes: source ticks are one-cycle pulses on core_clk
// Notes: a prescale of zero behaves as one
`timescale 1ns/1ps
`default_nettype none
module hfpb_pwm_channel (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // source clock edges
    input wire logic srcFastTick,
    input wire logic srcSlowTick,
    // settings
    input wire hfpb_pkg::hfpb_freq_t freq,
    input wire logic [7:0] duty,
    input wire logic dcMode,
    // drive
    output logic pwmOut,
    output logic [5:0] dcLevel
);
    import hfpb_pkg::*;

    logic [6:0] preCnt_q, preCnt_d;
    logic [7:0] perCnt_q, perCnt_d;
    logic pwmOut_q, pwmOut_d;
    logic [5:0] dcLevel_q, dcLevel_d;
    logic tick;
    logic [6:0] scaleEff;

    // ========================================
    // prescaler and period counter
    always_comb begin
        tick = freq.clkSel ? srcSlowTick : srcFastTick;
        scaleEff = (freq.scale == 7'h00) ? 7'h01 : freq.scale;
        preCnt_d = preCnt_q;
        perCnt_d = perCnt_q;
        if (tick) begin
            if (preCnt_q + 7'h01 >= scaleEff) begin
                preCnt_d = 7'h00;
                perCnt_d = perCnt_q + 8'h01;
            end else begin
                preCnt_d = preCnt_q + 7'h01;
            end
        end
        // full scale is held solid so that ff really means always on
        pwmOut_d = !dcMode && ((duty == DUTY_FULL) || (perCnt_q < duty));
        dcLevel_d = dcMode ? duty[7:2] : 6'h00;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            preCnt_q <= 7'h00;
            perCnt_q <= 8'h00;
            pwmOut_q <= 1'b0;
            dcLevel_q <= 6'h00;
        end else begin
            preCnt_q <= preCnt_d;
            perCnt_q <= perCnt_d;
            pwmOut_q <= pwmOut_d;
            dcLevel_q <= dcLevel_d;
        end
    end

    assign pwmOut = pwmOut_q;
    assign dcLevel = dcLevel_q;

    // ========================================
    // checks
    a_full_duty: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!dcMode && duty == DUTY_FULL) |=> pwmOut) else $error("full duty not high");
    a_zero_duty: assert property (@(posedge core_clk) disable iff (!rst_b)
        (duty == 8'h00) |=> !pwmOut) else $error("zero duty not low");
    a_prescale_bound: assert property (@(posedge core_clk) disable iff (!rst_b)
        (tick && freq.scale > 7'h01 && preCnt_q == 7'h00) |=> (perCnt_q == $past(perCnt_q)))
        else $error("period stepped before prescale count");
    a_dc_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
        dcMode |=> !pwmOut ##0 (dcLevel == $past(duty[7:2]))) else $error("dc mode output wrong");
    c_pwm_rise: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(pwmOut));
endmodule
`default_nettype wire

//--- hfpb_fan_alarm_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- hfpb_fan_env.sv
// Purpose: far side of the block: fan source oscillators and the pulled-up alarm line
// Assumes: both source clocks run free, as board oscillators do
// Notes: the alarm line floats high through a pull-up unless the block pulls it low
`timescale 1ns/1ps
`default_nettype none
module hfpb_fan_env (
    // source clocks
    output var logic fastClk,
    output var logic slowClk,
    // alarm line
    input wire logic pinOe,
    input wire logic pinOut,
    output wire logic pinLevel
);
    // ========================================
    // oscillators, phase unrelated to core_clk
    // one process per clock so each has a single driver
    initial begin
        fastClk = 1'b0;
        forever #20.833 fastClk = ~fastClk;
    end
    initial begin
        slowClk = 1'b0;
        forever #2777.778 slowClk = ~slowClk;
    end
    // pull-up wins whenever the block releases the line
    assign pinLevel = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

//--- hfpb_fan_alarm_tb.sv
// Purpose: self-checking bench for the fan drive and alarm tone block
// Assumes: monitor base 0290h, moved to 0310h after the second reset; shortened tone counts
// Notes: pwm ratios are checked in bands because the source clock is sampled
`timescale 1ns/1ps
`default_nettype none
module hfpb_fan_alarm_tb;
    import hfpb_pkg::*;
    localparam logic [15:0] IX = 16'h0295;
    localparam logic [15:0] DX = 16'h0296;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    hfpb_io_req_t ioReq = '0;
    logic [7:0] baseHi = 8'h02;
    logic [7:0] baseLo = 8'h90;
    logic strap = 1'b1;
    logic [16:0] alarmEvents = '0;
    logic [7:0] ioRdData, d;
    logic ioRdValid, v, p, sysPwm, sysType, cpuPwm, cpuType, fastClk, slowClk, pinOut, pinOe, pinLevel;
    logic [5:0] sysDc, cpuDc;
    int fails = 0;
    int samples_checked = 0;
    int h, t, s, n;
    // ========================================
    // clock, design and far side
    always #10 core_clk = ~core_clk;
    hfpb_fan_alarm #(.PHASE_CYCLES(200), .LOW_HALF_CYCLES(10), .HIGH_HALF_CYCLES(5)) dut (
        .core_clk(core_clk), .rst_b(rst_b), .ioReq(ioReq), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
        .monitorBaseHigh(baseHi), .monitorBaseLow(baseLo), .srcFastClkPin(fastClk), .srcSlowClkPin(slowClk),
        .fanSetStrap(strap), .alarmEvents(alarmEvents), .systemFanPwm(sysPwm), .systemFanDcLevel(sysDc),
        .systemFanTypeSelect(sysType), .processorFanPwm(cpuPwm), .processorFanDcLevel(cpuDc),
        .processorFanTypeSelect(cpuType), .alarmTonePinIn(pinLevel), .alarmTonePinOut(pinOut),
        .alarmTonePinOe(pinOe));
    hfpb_fan_env env (.fastClk(fastClk), .slowClk(slowClk), .pinOe(pinOe), .pinOut(pinOut), .pinLevel(pinLevel));
    // ========================================
    // helpers
    task automatic results();
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one host cycle; the answer is awaited for a bounded three cycles
    task automatic acc(input logic [15:0] a, input logic r, input logic [7:0] w);
        @(posedge core_clk) #1 ioReq = '{addr: a, wr: !r, rd: r, wdata: w};
        @(posedge core_clk) #1 ioReq = '0;
        v = 1'b0;
        for (n = 0; n < 3 && v !== 1'b1; n++) begin
            if (n > 0) @(posedge core_clk) #1;
            v = ioRdValid;
        end
        d = ioRdData;
    endtask
    task automatic set(input logic [6:0] i, input logic [7:0] w);
        acc(IX, 1'b0, {1'b0, i});
        acc(DX, 1'b0, w);
    endtask
    task automatic rr(input logic [6:0] i, input logic [7:0] e);
        acc(IX, 1'b0, {1'b0, i});
        acc(DX, 1'b1, 8'h00);
        chk(d, e);
    endtask
    // skip a released high already running, then time one whole released high half
    task automatic tone();
        for (n = 0; n < 40 && pinOe === 1'b0; n++) @(posedge core_clk) #1;
        for (n = 0; n < 40 && pinOe !== 1'b0; n++) @(posedge core_clk) #1;
        for (h = 0; h < 40 && pinOe === 1'b0; h++) @(posedge core_clk) #1;
    endtask
    // high time and edges of the processor fan, high time of the system fan, two fast periods
    task automatic meas();
        repeat (600) @(posedge core_clk);
        #1 p = cpuPwm;
        h = 0; t = 0; s = 0;
        repeat (1066) begin
            @(posedge core_clk) #1 h += cpuPwm;
            t += (cpuPwm !== p);
            s += sysPwm;
            p = cpuPwm;
        end
    endtask
    // ========================================
    // watchdog, well beyond the expected run
    initial begin
        #600000;
        fails++;
        results();
    end
    // ========================================
    // test sequence
    initial begin
        repeat (8) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge core_clk);
        #1 chk({6'h0, sysType, cpuType}, 8'h02);
        chk({6'h0, pinOut, pinOe}, 8'h01);
        acc(IX, 1'b1, 8'h00);
        chk(d, {1'b0, INDEX_RST});
        rr(IDX_SYS_FREQ, FREQ_RST);
        rr(IDX_CPU_FREQ, FREQ_RST);
        rr(IDX_FAN_CFG, FAN_CFG_RST);
        rr(IDX_SYS_VALUE, STRAP_HIGH_VALUE);
        chk({2'h0, sysDc}, 8'h3f);
        acc(IX, 1'b0, 8'hff);
        acc(IX, 1'b1, 8'h00);
        chk(d, 8'h7f);
        acc(16'h0294, 1'b1, 8'h00);
        chk({7'h0, v}, 8'h00);
        set(IDX_SYS_VALUE, 8'ha7);
        rr(IDX_SYS_VALUE, 8'ha7);
        chk({2'h0, sysDc}, 8'h29);
        // banked window: bank 4 hides the bank 0 enables
        set(IDX_BANK_SEL, BANK_ALARM_C);
        set(IDX_ALARM_EN_A, 8'hff);
        rr(IDX_ALARM_EN_A, 8'h00);
        rr(IDX_BANK_SEL, BANK_ALARM_C);
        rr(IDX_SYS_FREQ, FREQ_RST);
        set(IDX_ALARM_EN_C, 8'h03);
        rr(IDX_ALARM_EN_C, 8'h03);
        set(IDX_BANK_SEL, BANK_ALARM_AB);
        rr(IDX_ALARM_EN_C, 8'h00);
        // alarm: enabled event with the global enable off, then on, then only an unenabled event
        set(IDX_ALARM_EN_A, 8'h01);
        alarmEvents = 17'h00003;
        h = 0;
        repeat (40) @(posedge core_clk) #1 h += !pinOe;
        chk(h[7:0], 8'h00);
        set(IDX_ALARM_EN_B, 8'h80);
        tone();
        chk(h[7:0], 8'h0a);
        repeat (200) @(posedge core_clk);
        #1 tone();
        chk(h[7:0], 8'h05);
        alarmEvents = 17'h00002;
        h = 0;
        repeat (20) @(posedge core_clk) #1 h += !pinOe;
        chk(h[7:0], 8'h00);
        // processor fan pwm on the fast source, scale one, then on the slow source
        set(IDX_CPU_FREQ, 8'h01);
        set(IDX_CPU_VALUE, 8'h00);
        meas();
        chk(h[7:0], 8'h00);
        chk(s[7:0], 8'h00);
        set(IDX_CPU_VALUE, DUTY_FULL);
        meas();
        chk({7'h0, h == 1066}, 8'h01);
        set(IDX_CPU_VALUE, 8'h80);
        meas();
        chk({7'h0, h > 400 && h < 666}, 8'h01);
        chk({7'h0, t >= 3}, 8'h01);
        set(IDX_CPU_FREQ, 8'h81);
        meas();
        chk({7'h0, t <= 1}, 8'h01);
        // processor fan to dc, system fan to pwm at full duty
        set(IDX_FAN_CFG, 8'h02);
        set(IDX_SYS_VALUE, DUTY_FULL);
        meas();
        chk({6'h0, sysType, cpuType}, 8'h01);
        chk({7'h0, s == 1066}, 8'h01);
        chk(h[7:0], 8'h00);
        chk({2'h0, cpuDc}, 8'h20);
        chk({2'h0, sysDc}, 8'h00);
        // second reset with the strap low, then the base moved
        strap = 1'b0;
        @(posedge core_clk) #1 rst_b = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 rst_b = 1'b1;
        repeat (6) @(posedge core_clk);
        #1 chk({6'h0, pinOut, pinOe}, 8'h01);
        rr(IDX_SYS_VALUE, STRAP_LOW_VALUE);
        chk({2'h0, sysDc}, 8'h20);
        baseHi = 8'h03;
        baseLo = 8'h10;
        acc(16'h0315, 1'b0, {1'b0, IDX_CPU_VALUE});
        acc(16'h0316, 1'b1, 8'h00);
        chk(d, STRAP_LOW_VALUE);
        acc(IX, 1'b1, 8'h00);
        chk({7'h0, v}, 8'h00);
        results();
    end
endmodule
`default_nettype wire
